/* File: common/mgmt_status_pkg.sv */
// constants for the management characteristic and global status bytes
// assumes one core clock of 40 MHz and a host-clocked serial management link
package mgmt_status_pkg;
  localparam logic [6:0] CHAR_OFS = 7'h02;
  localparam logic [6:0] STAT_OFS = 7'h03;
  localparam logic [6:0] HOT_APPLY_OFS = 7'h7E;
  localparam logic [6:0] REINIT_APPLY_OFS = 7'h7F;
  localparam int FLAT_BIT = 7;
  localparam int STEPWISE_BIT = 6;
  localparam int RATE_MSB = 5;
  localparam int RATE_LSB = 2;
  localparam int RECONF_MSB = 1;
  localparam int RECONF_LSB = 0;
  localparam int STATE_MSB = 3;
  localparam int STATE_LSB = 1;
  localparam int IRQ_BIT = 0;
  localparam logic [3:0] TW_RATE_MAX = 4'h2;
  localparam logic [3:0] SPI_RATE_MAX = 4'h9;
  localparam logic [1:0] RECONF_NONE = 2'h0;
  localparam logic [1:0] RECONF_REGULAR = 2'h1;
  localparam logic [1:0] RECONF_HOT = 2'h2;
  localparam logic [2:0] ST_LOW_POWER = 3'h1;
  localparam logic [2:0] ST_POWERING_UP = 3'h2;
  localparam logic [2:0] ST_OPERATIONAL = 3'h3;
  localparam logic [2:0] ST_POWERING_DOWN = 3'h4;
  localparam logic [2:0] ST_FAULTED = 3'h5;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h03;
  localparam logic [3:0] CMD_LAST = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'hF;
endpackage

/* File: common/bit_sync_if.sv */
// one level crossing into the core clock domain
// the source drives d from another domain or a pin
`timescale 1ns/1ps
`default_nettype none
interface bit_sync_if;
  logic d;
  logic q;
  modport src (output d, input q);
  modport dst (input d, output q);
endinterface
`default_nettype wire

/* File: hdl/bit_sync.sv */
// three-stage synchroniser for one level
// d is asynchronous to clk; q moves only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module bit_sync
  import mgmt_status_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  bit_sync_if.dst s
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  // s1_r feeds s2_r only
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= s.d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= RST_VAL;
    end else if (s2_r == s3_r) begin
      q_r <= s3_r;
    end
  end

  assign s.q = q_r;
endmodule
`default_nettype wire

/* File: hdl/mgmt_status_regs.sv */
// management characteristic byte and global status byte, read over the link
// assumes unit state on CLK; straps, interrupt pin and link from outside
//
// How it works
// [RULE_01] link rate limit sits in characteristics bits 5 to 2
// [RULE_02] two-wire link codes 0,1,2 give 400 kHz, 1 MHz, 3.4 MHz
// [RULE_03] four-wire link codes 0 to 9 give 1 up to 50 MHz
// [RULE_04] bits 1 to 0 name at most one supported unattended procedure
// [RULE_05] with stepwise-only clear both procedures work, field is don't care
// [RULE_06] with stepwise-only set: 00 none, 01 regular, 10 hot, 11 reserved
// [RULE_07] hot apply trigger writes are dropped when hot is unsupported
// [RULE_08] no regular support: reinit trigger always provisions, reinit term off
// [RULE_09] unit condition code sits in status bits 3 to 1, read only
// [RULE_10] flat memory units always report the operational code
// [RULE_11] some internal conditions never show in the reported code
// [RULE_12] status bit 0 is one when interrupt idle, zero when asserted
// [RULE_13] codes 1 low power,2 up,3 operational,4 down,5 faulted
// [RULE_14] characteristics bit 6 is the stepwise-only indicator
// [RULE_15] interrupt status follows the real level of the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module mgmt_status_regs
  import mgmt_status_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic FLAT_MEM,
  input wire logic LINK_IS_FOUR_WIRE,
  input wire logic [3:0] RATE_STRAP,
  input wire logic STEPWISE_STRAP,
  input wire logic [1:0] RECONF_STRAP,
  input wire logic [2:0] UNIT_STATE,
  input wire logic IRQ_PIN_N,
  input wire logic LINK_SCK,
  input wire logic LINK_CS_N,
  input wire logic LINK_MOSI,
  output logic LINK_MISO,
  output logic LINK_MISO_OE,
  output logic HOT_APPLY_STB,
  output logic REINIT_APPLY_STB,
  output logic PROVISION_STB,
  output logic [7:0] APPLY_DATA,
  output logic REINIT_TERM_EN
);
  typedef enum logic [1:0] {FR_CMD, FR_DATA, FR_DONE} frame_e;
  typedef struct packed {
    logic flat;
    logic four_wire;
    logic [3:0] rate;
    logic stepwise;
    logic [1:0] reconf;
  } strap_s;

  // ---------------- core domain ----------------
  strap_s strap_s1_r;
  strap_s strap_s2_r;
  strap_s strap_s3_r;
  strap_s strap_q_r;
  logic flat_r;
  logic four_wire_r;
  logic [3:0] rate_r;
  logic stepwise_r;
  logic [1:0] reconf_r;
  logic [2:0] code_r;
  logic [7:0] char_byte;
  logic [7:0] stat_byte;
  logic [15:0] snap_r;
  logic req_r;
  logic hot_ok;
  logic reg_ok;
  logic irq_idle;
  logic ack_s;
  logic wr_s;
  logic wr_seen_r;
  logic hot_stb_r;
  logic reinit_stb_r;
  logic prov_stb_r;
  logic [7:0] apply_data_r;
  logic [3:0] rate_nxt;
  logic [1:0] reconf_nxt;

  // ---------------- link domain ----------------
  frame_e lk_st_r;
  logic [3:0] lk_cnt_r;
  logic [7:0] lk_sh_r;
  logic [7:0] lk_cmd_r;
  logic [7:0] lk_tx_r;
  logic lk_miso_r;
  logic [7:0] lk_rd_byte;
  logic [6:0] lk_addr_now;
  logic lk_wr_fire;
  logic [6:0] lk_wa_r;
  logic [7:0] lk_wd_r;
  logic lk_wr_tgl_r;
  logic lk_rq1_r;
  logic lk_rq2_r;
  logic lk_rq3_r;
  logic lk_ack_r;
  logic [15:0] lk_stat_r;

  bit_sync_if irq_if ();
  bit_sync_if ack_if ();
  bit_sync_if wr_if ();

  assign irq_if.d = IRQ_PIN_N;
  assign ack_if.d = lk_ack_r;
  assign wr_if.d = lk_wr_tgl_r;
  assign irq_idle = irq_if.q;
  assign ack_s = ack_if.q;
  assign wr_s = wr_if.q;

  bit_sync #(.RST_VAL(1'b1)) u_irq_sync (
    .clk(CLK),
    .rst(RST),
    .s(irq_if.dst)
  );

  bit_sync #(.RST_VAL(1'b0)) u_ack_sync (
    .clk(CLK),
    .rst(RST),
    .s(ack_if.dst)
  );

  bit_sync #(.RST_VAL(1'b0)) u_wr_sync (
    .clk(CLK),
    .rst(RST),
    .s(wr_if.dst)
  );

  // straps are pins too: three stages, reset is long enough for them to settle
  always_ff @(posedge CLK) begin
    strap_s1_r <= {FLAT_MEM, LINK_IS_FOUR_WIRE, RATE_STRAP, STEPWISE_STRAP, RECONF_STRAP};
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
  end

  always_ff @(posedge CLK) begin
    if (strap_s2_r == strap_s3_r) begin
      strap_q_r <= strap_s3_r;
    end
  end

  // strap values are caught while reset is held, frozen after release
  always_ff @(posedge CLK) begin
    if (RST) begin
      flat_r <= strap_q_r.flat;
      four_wire_r <= strap_q_r.four_wire;
      rate_r <= rate_nxt;
      stepwise_r <= strap_q_r.stepwise;
      reconf_r <= reconf_nxt;
    end
  end

  // a reserved strap falls back to the slowest rate
  always_comb begin
    rate_nxt = strap_q_r.rate;
    if (strap_q_r.four_wire && strap_q_r.rate > SPI_RATE_MAX) begin
      rate_nxt = 4'h0; // RULE_03
    end else if (!strap_q_r.four_wire && strap_q_r.rate > TW_RATE_MAX) begin
      rate_nxt = 4'h0; // RULE_02
    end
  end

  // reserved 11 is never advertised; don't care field reads zero
  always_comb begin
    reconf_nxt = strap_q_r.reconf;
    if (!strap_q_r.stepwise) begin
      reconf_nxt = RECONF_NONE; // RULE_05
    end else if (strap_q_r.reconf == 2'h3) begin
      reconf_nxt = RECONF_NONE; // RULE_06
    end
  end

  assign hot_ok = !stepwise_r || (reconf_r == RECONF_HOT); // RULE_05
  assign reg_ok = !stepwise_r || (reconf_r == RECONF_REGULAR); // RULE_06

  // reserved input codes keep the last valid one, so hidden states never leak
  always_ff @(posedge CLK) begin
    if (RST) begin
      // first snapshot after release already carries the flat code
      code_r <= strap_q_r.flat ? ST_OPERATIONAL : ST_LOW_POWER; // RULE_10
    end else if (flat_r) begin
      code_r <= ST_OPERATIONAL; // RULE_10
    end else begin
      case (UNIT_STATE)
        ST_LOW_POWER: code_r <= UNIT_STATE; // RULE_13
        ST_POWERING_UP: code_r <= UNIT_STATE;
        ST_OPERATIONAL: code_r <= UNIT_STATE;
        ST_POWERING_DOWN: code_r <= UNIT_STATE;
        ST_FAULTED: code_r <= UNIT_STATE;
        default: code_r <= code_r; // RULE_11
      endcase
    end
  end

  always_comb begin
    char_byte = CHAR_RST;
    char_byte[FLAT_BIT] = flat_r;
    char_byte[STEPWISE_BIT] = stepwise_r; // RULE_14
    char_byte[RATE_MSB:RATE_LSB] = rate_r; // RULE_01
    char_byte[RECONF_MSB:RECONF_LSB] = reconf_r; // RULE_04
  end

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[STATE_MSB:STATE_LSB] = code_r; // RULE_09
    stat_byte[IRQ_BIT] = irq_idle; // RULE_12 RULE_15
  end

  // snapshot only changes while the link side has taken the previous one
  always_ff @(posedge CLK) begin
    if (RST) begin
      snap_r <= {CHAR_RST, STAT_RST};
      req_r <= 1'b0;
    end else if (ack_s == req_r) begin
      snap_r <= {char_byte, stat_byte}; // RULE_15
      req_r <= ~req_r;
    end
  end

  // write triggers from the link, at most one per toggle of its write flag
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_seen_r <= 1'b0;
      hot_stb_r <= 1'b0;
      reinit_stb_r <= 1'b0;
      prov_stb_r <= 1'b0;
      apply_data_r <= 8'h00;
    end else begin
      hot_stb_r <= 1'b0;
      reinit_stb_r <= 1'b0;
      prov_stb_r <= 1'b0;
      if (wr_s != wr_seen_r) begin
        wr_seen_r <= wr_s;
        if (lk_wa_r == HOT_APPLY_OFS && hot_ok) begin
          hot_stb_r <= 1'b1; // RULE_07
          apply_data_r <= lk_wd_r;
        end
        if (lk_wa_r == REINIT_APPLY_OFS) begin
          reinit_stb_r <= 1'b1;
          prov_stb_r <= !reg_ok; // RULE_08
          apply_data_r <= lk_wd_r;
        end
      end
    end
  end

  assign HOT_APPLY_STB = hot_stb_r;
  assign REINIT_APPLY_STB = reinit_stb_r;
  assign PROVISION_STB = prov_stb_r;
  assign APPLY_DATA = apply_data_r;
  assign REINIT_TERM_EN = reg_ok; // RULE_08

  // ---------------- link side, runs only inside frames ----------------
  // frame state is cleared by chip select, the clock may be stopped
  always_ff @(posedge LINK_SCK or posedge LINK_CS_N) begin
    if (LINK_CS_N) begin
      lk_st_r <= FR_CMD;
      lk_cnt_r <= 4'h0;
      lk_sh_r <= 8'h00;
      lk_cmd_r <= 8'h00;
    end else begin
      lk_sh_r <= {lk_sh_r[6:0], LINK_MOSI};
      lk_cnt_r <= lk_cnt_r + 4'h1;
      case (lk_st_r)
        FR_CMD: begin
          if (lk_cnt_r == CMD_LAST) begin
            lk_cmd_r <= {lk_sh_r[6:0], LINK_MOSI};
            lk_st_r <= FR_DATA;
          end
        end
        FR_DATA: begin
          if (lk_cnt_r == FRAME_LAST) begin
            lk_st_r <= FR_DONE;
          end
        end
        FR_DONE: lk_st_r <= FR_DONE;
        default: lk_st_r <= FR_CMD;
      endcase
    end
  end

  assign lk_addr_now = {lk_sh_r[5:0], LINK_MOSI};
  assign lk_wr_fire = (lk_st_r == FR_DATA) && (lk_cnt_r == FRAME_LAST) && !lk_cmd_r[7];

  // trigger registers and unmapped offsets read zero
  always_comb begin
    case (lk_addr_now)
      CHAR_OFS: lk_rd_byte = lk_stat_r[15:8];
      STAT_OFS: lk_rd_byte = lk_stat_r[7:0];
      default: lk_rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge LINK_SCK or posedge LINK_CS_N) begin
    if (LINK_CS_N) begin
      lk_tx_r <= 8'h00;
    end else if (lk_st_r == FR_CMD && lk_cnt_r == CMD_LAST) begin
      lk_tx_r <= lk_sh_r[6] ? lk_rd_byte : 8'h00;
    end else begin
      lk_tx_r <= {lk_tx_r[6:0], 1'b0};
    end
  end

  // shifted on the falling edge so the host samples on the rising one
  always_ff @(negedge LINK_SCK or posedge LINK_CS_N) begin
    if (LINK_CS_N) begin
      lk_miso_r <= 1'b0;
    end else begin
      lk_miso_r <= lk_tx_r[7];
    end
  end

  assign LINK_MISO = lk_miso_r;
  assign LINK_MISO_OE = !LINK_CS_N && lk_cmd_r[7] && (lk_st_r == FR_DATA);

  // write holding registers outlive the frame; core reads them after the toggle
  always_ff @(posedge LINK_SCK or posedge RST) begin
    if (RST) begin
      lk_wa_r <= 7'h00;
      lk_wd_r <= 8'h00;
      lk_wr_tgl_r <= 1'b0;
    end else if (lk_wr_fire) begin
      lk_wa_r <= lk_cmd_r[6:0];
      lk_wd_r <= {lk_sh_r[6:0], LINK_MOSI};
      lk_wr_tgl_r <= ~lk_wr_tgl_r;
    end
  end

  // snapshot fetch: a stale copy is possible after long idle, one frame late
  always_ff @(posedge LINK_SCK or posedge RST) begin
    if (RST) begin
      lk_rq1_r <= 1'b0;
      lk_rq2_r <= 1'b0;
      lk_rq3_r <= 1'b0;
    end else begin
      lk_rq1_r <= req_r;
      lk_rq2_r <= lk_rq1_r;
      lk_rq3_r <= lk_rq2_r;
    end
  end

  always_ff @(posedge LINK_SCK or posedge RST) begin
    if (RST) begin
      lk_ack_r <= 1'b0;
      lk_stat_r <= {CHAR_RST, STAT_RST};
    end else if (lk_rq2_r == lk_rq3_r && lk_rq3_r != lk_ack_r) begin
      lk_stat_r <= snap_r;
      lk_ack_r <= lk_rq3_r;
    end
  end
endmodule
`default_nettype wire

/* File: bench/mgmt_status_sva.sv */
// port checks for the characteristics and status block
// assumes straps change only while RST is high
`timescale 1ns/1ps
`default_nettype none
module mgmt_status_sva
  import mgmt_status_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic STEPWISE_STRAP,
  input wire logic [1:0] RECONF_STRAP,
  input wire logic LINK_CS_N,
  input wire logic LINK_MISO_OE,
  input wire logic HOT_APPLY_STB,
  input wire logic REINIT_APPLY_STB,
  input wire logic PROVISION_STB,
  input wire logic [7:0] APPLY_DATA,
  input wire logic REINIT_TERM_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  term_follows_a: assert property (REINIT_TERM_EN ==
    (!STEPWISE_STRAP || RECONF_STRAP == RECONF_REGULAR)) else $error("reinit term wrong");
  prov_pair_a: assert property ((REINIT_APPLY_STB || PROVISION_STB) |->
    REINIT_APPLY_STB && PROVISION_STB == !REINIT_TERM_EN) else $error("provision wrong");
  hot_drop_a: assert property (HOT_APPLY_STB |->
    !STEPWISE_STRAP || RECONF_STRAP == RECONF_HOT) else $error("hot write not dropped");
  hot_alone_a: assert property (HOT_APPLY_STB |->
    !REINIT_APPLY_STB && !PROVISION_STB) else $error("strobes overlap");
  stb_pulse_a: assert property ((HOT_APPLY_STB || REINIT_APPLY_STB) |=>
    !HOT_APPLY_STB && !REINIT_APPLY_STB) else $error("strobe too long");
  oe_idle_a: assert property (LINK_CS_N |-> !LINK_MISO_OE)
    else $error("miso driven while idle");
  rst_clear_a: assert property ($fell(RST) |-> APPLY_DATA == 8'h00 &&
    !HOT_APPLY_STB && !REINIT_APPLY_STB) else $error("reset values wrong");
  data_hold_a: assert property (!$stable(APPLY_DATA) |->
    HOT_APPLY_STB || REINIT_APPLY_STB) else $error("apply data moved");
endmodule
`default_nettype wire

/* File: bench/link_host.sv */
// host side of the serial link, mode 0, 16 bit frames, msb first
// assumes the device moves miso on falling sck
`timescale 1ns/1ps
`default_nettype none
module link_host (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // sck runs only inside a frame, 48 ns period
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] tx;
    tx = {cmd, wd};
    rd = 8'h00;
    #7 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      // taken just ahead of the rising edge, before the device moves its enable
      #24;
      if (i < 8) rd = {rd[6:0], miso};
      sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    // released line shows the inverse, never a stale bit
    mosi = ~mosi;
    // write frames need 1 us between ends
    #1000;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench: strap sets, byte reads, trigger writes
// assumes the host model owns the link; straps move only under reset
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mgmt_status_pkg::*;
;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic flat = 1'b0, four = 1'b0, step = 1'b0, irq_n = 1'b1;
  logic [3:0] rate = 4'h0;
  logic [1:0] rc = 2'h0;
  logic [2:0] st = 3'h1;
  wire sck, cs_n, mosi, miso, miso_oe, hot, rei, prov, term;
  // undriven line floats high, so a missing enable shows up in read data
  wire miso_line = miso_oe ? miso : 1'b1;
  wire [7:0] ad;
  logic [7:0] hot_n = 8'h00, rei_n = 8'h00, prov_n = 8'h00, last = 8'h00, rd;
  int failures = 0;
  int tests_run = 0;
  // flat, four, rate, stepwise, reconf, state, irq
  logic [12:0] cfg [5] = '{13'h0165, 13'h01DA, 13'h0CF9, 13'h1D22, 13'h0847};
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    if (RST) begin
      hot_n <= 8'h00;
      rei_n <= 8'h00;
      prov_n <= 8'h00;
    end else begin
      if (hot) hot_n <= hot_n + 8'h01;
      if (rei) rei_n <= rei_n + 8'h01;
      if (prov) prov_n <= prov_n + 8'h01;
    end
    if (hot || rei) last <= ad;
  end
  mgmt_status_regs mgmt_status_regs_inst (.CLK(CLK), .RST(RST), .FLAT_MEM(flat),
    .LINK_IS_FOUR_WIRE(four), .RATE_STRAP(rate), .STEPWISE_STRAP(step),
    .RECONF_STRAP(rc), .UNIT_STATE(st), .IRQ_PIN_N(irq_n), .LINK_SCK(sck),
    .LINK_CS_N(cs_n), .LINK_MOSI(mosi), .LINK_MISO(miso), .LINK_MISO_OE(miso_oe),
    .HOT_APPLY_STB(hot), .REINIT_APPLY_STB(rei), .PROVISION_STB(prov),
    .APPLY_DATA(ad), .REINIT_TERM_EN(term));
  link_host link_host_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_line));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // first read after idle may be stale, so read twice
  task automatic rd2(input logic [6:0] ofs, input logic [7:0] exp);
    link_host_inst.xfer({1'b1, ofs}, 8'h00, rd);
    link_host_inst.xfer({1'b1, ofs}, 8'h00, rd);
    chk(rd, exp);
  endtask
  task automatic test_done;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] ch;
    logic okr, hot_ok, reg_ok;
    foreach (cfg[i]) begin
      @(posedge CLK);
      RST <= 1'b1;
      {flat, four, rate, step, rc, st, irq_n} <= cfg[i];
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      repeat (12) @(posedge CLK);
      okr = rate <= (four ? SPI_RATE_MAX : TW_RATE_MAX);
      ch = {flat, step, okr ? rate : 4'h0, (step && rc != 2'h3) ? rc : RECONF_NONE};
      hot_ok = !step || rc == RECONF_HOT;
      reg_ok = !step || rc == RECONF_REGULAR;
      rd2(CHAR_OFS, ch);
      rd2(STAT_OFS, {4'h0, flat ? ST_OPERATIONAL : st, irq_n});
      @(posedge CLK);
      irq_n <= ~irq_n;
      st <= 3'h7;
      repeat (8) @(posedge CLK);
      rd2(STAT_OFS, {4'h0, flat ? ST_OPERATIONAL : cfg[i][3:1], ~cfg[i][0]});
      link_host_inst.xfer({1'b0, REINIT_APPLY_OFS}, 8'h3C, rd);
      link_host_inst.xfer({1'b0, HOT_APPLY_OFS}, 8'hA5, rd);
      link_host_inst.xfer({1'b0, CHAR_OFS}, 8'hFF, rd);
      repeat (20) @(posedge CLK);
      chk(hot_n, {7'h00, hot_ok});
      chk(last, hot_ok ? 8'hA5 : 8'h3C);
      chk(rei_n, 8'h01);
      chk(prov_n, {7'h00, !reg_ok});
      chk({7'h00, term}, {7'h00, reg_ok});
      rd2(CHAR_OFS, ch);
      rd2(7'h10, 8'h00);
    end
    test_done;
  end
  // cuts a hang short
  initial begin
    #2000000;
    failures++;
    test_done;
  end
endmodule
bind mgmt_status_regs mgmt_status_sva mgmt_status_sva_inst (.CLK, .RST, .STEPWISE_STRAP,
  .RECONF_STRAP, .LINK_CS_N, .LINK_MISO_OE, .HOT_APPLY_STB, .REINIT_APPLY_STB,
  .PROVISION_STB, .APPLY_DATA, .REINIT_TERM_EN);
`default_nettype wire
